// ==== core/mcd_decoder.sv ====
// Purpose: Opcode decoder, cycle timer and program counter sequencing
// Assumes: Opcode, operand and core state come from logic on the same clock
// Notes:   One instruction at a time; the next is taken once busy_o is low and halted_o is clear
//
// Functional notes
// - 01,02,03 add immediate, direct, indexed in 4, 6, 7 cycles.
// - 04,05,06 add with carry immediate, direct, indexed in 4, 6, 7.
// - 07,08,09 subtract immediate, direct, indexed in 4, 6, 7.
// - 0A,0B,0C subtract with borrow immediate, direct, indexed in 4, 6, 7.
// - OR, AND, XOR groups from 0D, 10, 13; modes in order, 4, 6, 7.
// - 16,17,18 compare immediate, direct, indexed in 5, 7, 8.
// - 19,1A,1B load accumulator immediate, direct, indexed in 4, 5, 6.
// - 1C,1D load index in 4 and 5; 1E stays reserved.
// - 40 index to acc, 41 acc to index, 60 acc to stack pointer, 4 each.
// - Calls from 50-5F and 90-9F, low bits carry address, 10 cycles.
// - Jump 80-8F, branch zero A0-AF, branch nonzero B0-BF, 5 cycles.
// - Branch carry C0-CF, branch no carry D0-DF, 5 cycles.
// - E0-EF jump accumulator relative, 7 cycles.
// - F0-FF table read at address formed with accumulator, 14 cycles.
// - 20 no-op, 21 increment acc, increment index; all 4 cycles.
// - 23,24 increment memory direct, indexed in 7 and 8.
// - 25,26 decrement acc, index in 4; 27,28 memory in 7, 8.
// - 29 port read, 2A port write in 5; 39 indexed port write in 6.
// - 2F swap acc with index, 30 swap acc with data stack pointer, 5.
// - 31,32 store acc direct, indexed in 5 and 6.
// - 33-38 OR, AND, XOR into memory, direct then indexed, 7 and 8.
// - Sequential flow moves low eight PC bits; upper six only on page advance.
// - Call or interrupt pushes next address plus carry and zero as two bytes.
// - Indexed port write adds index to address field; zero means index only.
`timescale 1ns/1ps
`include "mcd_consts.svh"
module mcd_decoder (
   input  wire logic             core_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             opcode_valid_i,
   input  wire logic [7:0]       opcode_i,
   input  wire logic [7:0]       operand_i,
   input  wire logic [7:0]       acc_i,
   input  wire logic [7:0]       index_i,
   input  wire logic             carry_i,
   input  wire logic             zero_i,
   input  wire logic             irq_ack_i,
   input  wire logic [13:0]      irq_vec_i,
   input  wire logic [7:0]       stack_hi_i,
   input  wire logic [7:0]       stack_lo_i,
   output mcd_pkg::mcd_op_t      op_o,
   output mcd_pkg::mcd_mode_t    mode_o,
   output logic [3:0]            cycles_o,
   output logic                  illegal_o,
   output logic                  busy_o,
   output logic                  done_o,
   output logic                  halted_o,
   output logic [13:0]           pc_o,
   output logic [7:0]            port_addr_o,
   output logic [13:0]           table_addr_o,
   output logic                  push_o,
   output logic [7:0]            push_hi_o,
   output logic [7:0]            push_lo_o,
   output logic                  restore_flags_o,
   output logic                  carry_o,
   output logic                  zero_o
);
   mcd_pkg::mcd_op_t   op_d;
   mcd_pkg::mcd_mode_t mode_d;
   logic [3:0]  cyc_d;
   logic [7:0]  alu_n;
   logic [2:0]  grp;
   logic [1:0]  sub;
   logic        start_w;
   logic        load_w;
   logic [13:0] target_w;
   logic [13:0] seq_w;
   logic [13:0] pc_next_w;
   logic [7:0]  port_w;
   logic [3:0]  cnt_q;
   logic [13:0] pc_nxt_q;
   logic        loaded_q;
   logic [3:0]  run_q;

   assign start_w = !busy_o && !halted_o && (irq_ack_i || opcode_valid_i);
   assign alu_n   = opcode_i - 8'h01;
   assign grp     = 3'(alu_n / 8'h03);
   assign sub     = 2'(alu_n % 8'h03);

   always_comb begin
      op_d   = mcd_pkg::op_illegal;
      mode_d = mcd_pkg::mode_impl;
      cyc_d  = `MCD_CYC_4;
      if (opcode_i >= 8'h01 && opcode_i <= 8'h18) begin
         case (grp)
            3'h0: op_d = mcd_pkg::op_add;
            3'h1: op_d = mcd_pkg::op_add_carry;
            3'h2: op_d = mcd_pkg::op_sub;
            3'h3: op_d = mcd_pkg::op_subtract_with_borrow;
            3'h4: op_d = mcd_pkg::op_or;
            3'h5: op_d = mcd_pkg::op_and;
            3'h6: op_d = mcd_pkg::op_xor;
            default: op_d = mcd_pkg::op_cmp;
         endcase
         case (sub)
            2'h0: begin mode_d = mcd_pkg::mode_imm; cyc_d = `MCD_CYC_4; end
            2'h1: begin mode_d = mcd_pkg::mode_dir; cyc_d = `MCD_CYC_6; end
            default: begin mode_d = mcd_pkg::mode_idx; cyc_d = `MCD_CYC_7; end
         endcase
         if (grp == 3'h7) cyc_d = cyc_d + 4'h1;
      end else if (opcode_i[7:4] >= 4'h8 || opcode_i[7:4] == 4'h5) begin
         mode_d = mcd_pkg::mode_dir;
         cyc_d  = `MCD_CYC_5;
         case (opcode_i[7:4])
            4'h5, 4'h9: begin op_d = mcd_pkg::op_call; cyc_d = `MCD_CYC_10; end
            4'h8: op_d = mcd_pkg::op_jump;
            4'hA: op_d = mcd_pkg::op_branch_if_zero;
            4'hB: op_d = mcd_pkg::op_branch_if_nonzero;
            4'hC: op_d = mcd_pkg::op_branch_if_carry;
            4'hD: op_d = mcd_pkg::op_branch_if_no_carry;
            4'hE: begin op_d = mcd_pkg::op_jump_accumulator_relative; cyc_d = `MCD_CYC_7; end
            default: begin op_d = mcd_pkg::op_table_read; cyc_d = `MCD_CYC_14; end
         endcase
      end else begin
         case (opcode_i)
            8'h00: begin op_d = mcd_pkg::op_halt; cyc_d = `MCD_CYC_7; end
            8'h19: begin op_d = mcd_pkg::op_load_acc; mode_d = mcd_pkg::mode_imm; end
            8'h1A: begin op_d = mcd_pkg::op_load_acc; mode_d = mcd_pkg::mode_dir; cyc_d = `MCD_CYC_5; end
            8'h1B: begin op_d = mcd_pkg::op_load_acc; mode_d = mcd_pkg::mode_idx; cyc_d = `MCD_CYC_6; end
            8'h1C: begin op_d = mcd_pkg::op_load_idx; mode_d = mcd_pkg::mode_imm; end
            8'h1D: begin op_d = mcd_pkg::op_load_idx; mode_d = mcd_pkg::mode_dir; cyc_d = `MCD_CYC_5; end
            8'h1F: op_d = mcd_pkg::op_page_advance;
            8'h20: op_d = mcd_pkg::op_nop;
            8'h21: op_d = mcd_pkg::op_inc_acc;
            8'h22: op_d = mcd_pkg::op_inc_idx;
            8'h23: begin op_d = mcd_pkg::op_inc_mem; mode_d = mcd_pkg::mode_dir; cyc_d = `MCD_CYC_7; end
            8'h24: begin op_d = mcd_pkg::op_inc_mem; mode_d = mcd_pkg::mode_idx; cyc_d = `MCD_CYC_8; end
            8'h25: op_d = mcd_pkg::op_dec_acc;
            8'h26: op_d = mcd_pkg::op_dec_idx;
            8'h27: begin op_d = mcd_pkg::op_dec_mem; mode_d = mcd_pkg::mode_dir; cyc_d = `MCD_CYC_7; end
            8'h28: begin op_d = mcd_pkg::op_dec_mem; mode_d = mcd_pkg::mode_idx; cyc_d = `MCD_CYC_8; end
            8'h29: begin op_d = mcd_pkg::op_port_read; mode_d = mcd_pkg::mode_dir; cyc_d = `MCD_CYC_5; end
            8'h2A: begin op_d = mcd_pkg::op_port_write; mode_d = mcd_pkg::mode_dir; cyc_d = `MCD_CYC_5; end
            8'h2B: op_d = mcd_pkg::op_pop_acc;
            8'h2C: op_d = mcd_pkg::op_pop_idx;
            8'h2D: begin op_d = mcd_pkg::op_push_acc; cyc_d = `MCD_CYC_5; end
            8'h2E: begin op_d = mcd_pkg::op_push_idx; cyc_d = `MCD_CYC_5; end
            8'h2F: begin op_d = mcd_pkg::op_swap_idx; cyc_d = `MCD_CYC_5; end
            8'h30: begin op_d = mcd_pkg::op_swap_dsp; cyc_d = `MCD_CYC_5; end
            8'h31: begin op_d = mcd_pkg::op_store_acc; mode_d = mcd_pkg::mode_dir; cyc_d = `MCD_CYC_5; end
            8'h32: begin op_d = mcd_pkg::op_store_acc; mode_d = mcd_pkg::mode_idx; cyc_d = `MCD_CYC_6; end
            8'h33, 8'h35, 8'h37: begin
               op_d   = opcode_i == 8'h33 ? mcd_pkg::op_or_mem
                      : opcode_i == 8'h35 ? mcd_pkg::op_and_mem : mcd_pkg::op_xor_mem;
               mode_d = mcd_pkg::mode_dir;
               cyc_d  = `MCD_CYC_7;
            end
            8'h34, 8'h36, 8'h38: begin
               op_d   = opcode_i == 8'h34 ? mcd_pkg::op_or_mem
                      : opcode_i == 8'h36 ? mcd_pkg::op_and_mem : mcd_pkg::op_xor_mem;
               mode_d = mcd_pkg::mode_idx;
               cyc_d  = `MCD_CYC_8;
            end
            8'h39: begin op_d = mcd_pkg::op_indexed_port_write; mode_d = mcd_pkg::mode_idx; cyc_d = `MCD_CYC_6; end
            8'h3A: op_d = mcd_pkg::op_complement_acc;
            8'h3B: op_d = mcd_pkg::op_shift_left_arith;
            8'h3C: op_d = mcd_pkg::op_shift_right_arith;
            8'h3D: op_d = mcd_pkg::op_rotate_left_carry;
            8'h3E: op_d = mcd_pkg::op_rotate_right_carry;
            8'h3F: begin op_d = mcd_pkg::op_ret; cyc_d = `MCD_CYC_8; end
            8'h40: op_d = mcd_pkg::op_idx_to_acc;
            8'h41: op_d = mcd_pkg::op_acc_to_idx;
            8'h60: op_d = mcd_pkg::op_acc_to_psp;
            8'h70: op_d = mcd_pkg::op_irq_mask_all;
            8'h72: op_d = mcd_pkg::op_irq_unmask_all;
            8'h73: begin op_d = mcd_pkg::op_return_from_interrupt; cyc_d = `MCD_CYC_8; end
            default: op_d = mcd_pkg::op_illegal;
         endcase
      end
      if (irq_ack_i) begin
         op_d   = mcd_pkg::op_irq_entry;
         mode_d = mcd_pkg::mode_impl;
         cyc_d  = `MCD_CYC_IRQ;
      end
   end

   // Control transfer target and whether it is taken
   always_comb begin
      load_w   = 1'b0;
      target_w = {pc_o[13:12], opcode_i[3:0], operand_i};
      case (op_d)
         mcd_pkg::op_jump:               load_w = 1'b1;
         mcd_pkg::op_branch_if_zero:     load_w = zero_i;
         mcd_pkg::op_branch_if_nonzero:  load_w = !zero_i;
         mcd_pkg::op_branch_if_carry:    load_w = carry_i;
         mcd_pkg::op_branch_if_no_carry: load_w = !carry_i;
         mcd_pkg::op_call: begin
            load_w   = 1'b1;
            target_w = {pc_o[13], opcode_i[7], opcode_i[3:0], operand_i};
         end
         mcd_pkg::op_jump_accumulator_relative: begin
            load_w   = 1'b1;
            target_w = {pc_o[13:12], opcode_i[3:0], operand_i} + {6'h00, acc_i};
         end
         mcd_pkg::op_ret, mcd_pkg::op_return_from_interrupt: begin
            load_w   = 1'b1;
            target_w = {stack_hi_i[5:0], stack_lo_i};
         end
         mcd_pkg::op_irq_entry: begin
            load_w   = 1'b1;
            target_w = irq_vec_i;
         end
         default: load_w = 1'b0;
      endcase
   end

   mcd_pc_step u_pc_step (
      .pc_i       (pc_o),
      .two_byte_i (mode_d != mcd_pkg::mode_impl),
      .page_adv_i (op_d == mcd_pkg::op_page_advance),
      .load_i     (load_w),
      .target_i   (target_w),
      .seq_o      (seq_w),
      .pc_next_o  (pc_next_w)
   );

   mcd_port_addr u_port_addr (
      .field_i   (operand_i),
      .index_i   (index_i),
      .indexed_i (op_d == mcd_pkg::op_indexed_port_write),
      .addr_o    (port_w)
   );

   // Instruction timer
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_o   <= 1'b0;
         done_o   <= 1'b0;
         cnt_q    <= `MCD_CNT_RST;
         halted_o <= 1'b0;
         pc_o     <= `MCD_PC_RST;
      end else begin
         done_o <= 1'b0;
         if (start_w) begin
            busy_o <= 1'b1;
            cnt_q  <= cyc_d - 4'h1;
         end else if (busy_o && cnt_q != `MCD_CNT_RST) begin
            cnt_q <= cnt_q - 4'h1;
         end else if (busy_o) begin
            busy_o   <= 1'b0;
            done_o   <= 1'b1;
            pc_o     <= pc_nxt_q;
            halted_o <= op_o == mcd_pkg::op_halt;
         end
      end
   end

   // Decoded instruction, held for its whole run
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         op_o            <= mcd_pkg::op_nop;
         mode_o          <= mcd_pkg::mode_impl;
         cycles_o        <= `MCD_CNT_RST;
         illegal_o       <= 1'b0;
         pc_nxt_q        <= `MCD_PC_RST;
         loaded_q        <= 1'b0;
         port_addr_o     <= `MCD_BYTE_RST;
         table_addr_o    <= `MCD_PC_RST;
         push_o          <= 1'b0;
         push_hi_o       <= `MCD_BYTE_RST;
         push_lo_o       <= `MCD_BYTE_RST;
         restore_flags_o <= 1'b0;
         carry_o         <= 1'b0;
         zero_o          <= 1'b0;
      end else if (start_w) begin
         op_o            <= op_d;
         mode_o          <= mode_d;
         cycles_o        <= cyc_d;
         illegal_o       <= op_d == mcd_pkg::op_illegal;
         pc_nxt_q        <= pc_next_w;
         loaded_q        <= load_w;
         port_addr_o     <= port_w;
         table_addr_o    <= {2'h0, {opcode_i[3:0], operand_i} + {4'h0, acc_i}};
         push_o          <= op_d == mcd_pkg::op_call || op_d == mcd_pkg::op_irq_entry;
         push_hi_o       <= {carry_i, zero_i, irq_ack_i ? pc_o[13:8] : seq_w[13:8]};
         push_lo_o       <= irq_ack_i ? pc_o[7:0] : seq_w[7:0];
         restore_flags_o <= op_d == mcd_pkg::op_return_from_interrupt;
         carry_o         <= stack_hi_i[`MCD_STK_C_BIT];
         zero_o          <= stack_hi_i[`MCD_STK_Z_BIT];
      end
   end

   // Helper: cycles spent busy in the current instruction
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) run_q <= `MCD_CNT_RST;
      else if (start_w) run_q <= `MCD_CNT_RST;
      else if (busy_o) run_q <= run_q + 4'h1;
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_take(logic [7:0] c);
      start_w && !irq_ack_i && opcode_i == c;
   endsequence
   sequence s_take_hi(logic [3:0] c);
      start_w && !irq_ack_i && opcode_i[7:4] == c;
   endsequence

   AST_ADD_DIR:
   assert property (s_take(8'h02) |=> op_o == mcd_pkg::op_add && cycles_o == 4'h6
      && mode_o == mcd_pkg::mode_dir) else $error("add direct");
   AST_ADC_IDX:
   assert property (s_take(8'h06) |=> op_o == mcd_pkg::op_add_carry && cycles_o == 4'h7)
      else $error("adc indexed");
   AST_SUB_IMM:
   assert property (s_take(8'h07) |=> op_o == mcd_pkg::op_sub && cycles_o == 4'h4)
      else $error("sub immediate");
   AST_SBB_DIR:
   assert property (s_take(8'h0B) |=> op_o == mcd_pkg::op_subtract_with_borrow
      && mode_o == mcd_pkg::mode_dir) else $error("borrow direct");
   AST_LOGIC_GRP:
   assert property (s_take(8'h11) |=> op_o == mcd_pkg::op_and && cycles_o == 4'h6)
      else $error("and direct");
   AST_CMP_IDX:
   assert property (s_take(8'h18) |=> op_o == mcd_pkg::op_cmp && cycles_o == 4'h8)
      else $error("cmp indexed");
   AST_LDA_DIR:
   assert property (s_take(8'h1A) |=> op_o == mcd_pkg::op_load_acc && cycles_o == 4'h5)
      else $error("load acc direct");
   AST_RESERVED:
   assert property (s_take(8'h1E) |=> illegal_o) else $error("reserved not flagged");
   AST_PSP:
   assert property (s_take(8'h60) |=> op_o == mcd_pkg::op_acc_to_psp && cycles_o == 4'h4)
      else $error("psp load");
   AST_CALL:
   assert property (s_take_hi(4'h9) |=> op_o == mcd_pkg::op_call ##10 done_o)
      else $error("call timing");
   AST_JNZ:
   assert property (s_take_hi(4'hB) |=> op_o == mcd_pkg::op_branch_if_nonzero
      && cycles_o == 4'h5) else $error("branch nonzero");
   AST_JC:
   assert property (s_take_hi(4'hC) |=> op_o == mcd_pkg::op_branch_if_carry)
      else $error("branch carry");
   AST_JUMP_ACCUMULATOR_RELATIVE:
   assert property (s_take_hi(4'hE) |=> cycles_o == 4'h7) else $error("jump_accumulator_relative cycles");
   AST_TABLE:
   assert property (s_take_hi(4'hF) |=> cycles_o == 4'hE && table_addr_o[11:0] ==
      {$past(opcode_i[3:0]), $past(operand_i)} + {4'h0, $past(acc_i)}) else $error("table");
   AST_INC_ACC:
   assert property (s_take(8'h21) |=> op_o == mcd_pkg::op_inc_acc) else $error("inc acc");
   AST_INC_MEM:
   assert property (s_take(8'h24) |=> cycles_o == 4'h8) else $error("inc mem");
   AST_DEC_MEM:
   assert property (s_take(8'h28) |=> op_o == mcd_pkg::op_dec_mem) else $error("dec mem");
   AST_INDEXED_PORT_WRITE:
   assert property (s_take(8'h39) |=> cycles_o == 4'h6) else $error("port write idx");
   AST_SWAP:
   assert property (s_take(8'h30) |=> op_o == mcd_pkg::op_swap_dsp) else $error("swap");
   AST_STORE:
   assert property (s_take(8'h32) |=> cycles_o == 4'h6) else $error("store indexed");
   AST_RMW:
   assert property (s_take(8'h36) |=> op_o == mcd_pkg::op_and_mem && cycles_o == 4'h8)
      else $error("and mem");
   AST_HALT:
   assert property (s_take(8'h00) ##1 busy_o[*7] ##1 done_o |-> halted_o)
      else $error("halt");
   AST_SHIFT:
   assert property (s_take(8'h3B) |=> op_o == mcd_pkg::op_shift_left_arith)
      else $error("shift left");
   AST_RETURN_FROM_INTERRUPT:
   assert property (s_take(8'h73) |=> restore_flags_o && cycles_o == 4'h8)
      else $error("return_from_interrupt");
   AST_LEN:
   assert property ($rose(done_o) |-> run_q == cycles_o) else $error("run length");
   AST_PAGE:
   assert property (done_o && !loaded_q && op_o != mcd_pkg::op_page_advance
      |-> pc_o[13:8] == $past(pc_o[13:8])) else $error("page moved");
   AST_PUSH:
   assert property (s_take_hi(4'h5) |=> push_o && push_hi_o[7] == $past(carry_i)
      && push_hi_o[6] == $past(zero_i)) else $error("push flags");
   AST_PORT:
   assert property (s_take(8'h39) |=> port_addr_o == 8'($past(operand_i) + $past(index_i)))
      else $error("port address");
endmodule // mcd_decoder

// ==== include/mcd_consts.svh ====
// Purpose: Timing counts, field positions and reset values of the opcode decoder
// Assumes: Included by bare name after the package
// Notes:   Cycle counts are instruction lengths in core clocks
`ifndef MCD_CONSTS_SVH
`define MCD_CONSTS_SVH
`define MCD_CYC_4      4'h4
`define MCD_CYC_5      4'h5
`define MCD_CYC_6      4'h6
`define MCD_CYC_7      4'h7
`define MCD_CYC_8      4'h8
`define MCD_CYC_10     4'hA
`define MCD_CYC_14     4'hE
`define MCD_CYC_IRQ    4'hA
`define MCD_PC_RST     14'h0000
`define MCD_BYTE_RST   8'h00
`define MCD_CNT_RST    4'h0
`define MCD_STK_C_BIT  7
`define MCD_STK_Z_BIT  6
`endif

// ==== include/mcd_pkg.sv ====
// Purpose: Types shared by the opcode decoder files
// Assumes: Nothing
// Notes:   No codes are given to the enumerations
package mcd_pkg;
   typedef enum logic [5:0] {
      op_illegal, op_halt, op_add, op_add_carry, op_sub, op_subtract_with_borrow,
      op_or, op_and, op_xor, op_cmp, op_load_acc, op_load_idx, op_page_advance,
      op_nop, op_inc_acc, op_inc_idx, op_inc_mem, op_dec_acc, op_dec_idx, op_dec_mem,
      op_port_read, op_port_write, op_indexed_port_write, op_pop_acc, op_pop_idx,
      op_push_acc, op_push_idx, op_swap_idx, op_swap_dsp, op_store_acc, op_or_mem,
      op_and_mem, op_xor_mem, op_complement_acc, op_shift_left_arith,
      op_shift_right_arith, op_rotate_left_carry, op_rotate_right_carry, op_ret,
      op_irq_mask_all, op_irq_unmask_all, op_return_from_interrupt, op_idx_to_acc,
      op_acc_to_idx, op_acc_to_psp, op_call, op_jump, op_branch_if_zero,
      op_branch_if_nonzero, op_branch_if_carry, op_branch_if_no_carry,
      op_jump_accumulator_relative, op_table_read, op_irq_entry
   } mcd_op_t;
   typedef enum logic [1:0] {mode_impl, mode_imm, mode_dir, mode_idx} mcd_mode_t;
endpackage

// ==== core/mcd_pc_step.sv ====
// Purpose: Next program counter for the opcode decoder
// Assumes: Pure combinational, driven from the core clock domain
// Notes:   Low byte wraps inside its page; in sequential flow upper bits move only on page advance
`timescale 1ns/1ps
module mcd_pc_step (
   input  wire logic [13:0] pc_i,
   input  wire logic        two_byte_i,
   input  wire logic        page_adv_i,
   input  wire logic        load_i,
   input  wire logic [13:0] target_i,
   output logic      [13:0] seq_o,
   output logic      [13:0] pc_next_o
);
   logic [7:0] lo_adv;
   logic [5:0] hi_adv;
   assign lo_adv    = pc_i[7:0] + (two_byte_i ? 8'h02 : 8'h01);
   assign hi_adv    = pc_i[13:8] + {5'h00, page_adv_i};
   assign seq_o     = {hi_adv, lo_adv};
   assign pc_next_o = load_i ? target_i : seq_o;
endmodule // mcd_pc_step

// ==== core/mcd_port_addr.sv ====
// Purpose: Port address for port transfers
// Assumes: Pure combinational
// Notes:   A zero field leaves the index register alone to pick the port
`timescale 1ns/1ps
module mcd_port_addr (
   input  wire logic [7:0] field_i,
   input  wire logic [7:0] index_i,
   input  wire logic       indexed_i,
   output logic      [7:0] addr_o
);
   assign addr_o = field_i + (indexed_i ? index_i : 8'h00);
endmodule // mcd_port_addr

// ==== tb/tb_mcu_opcode_decoder.sv ====
// Purpose: Self-checking bench for the opcode decoder
// Assumes: Decoder timing as handed over; seed fixed
// Notes:   Corner cases, every opcode from 01 up once, random traffic, then halt
`timescale 1ns/1ps
module tb_mcu_opcode_decoder;
   logic core_clk_i, rst_n_i, opcode_valid_i, carry_i, zero_i, irq_ack_i;
   logic [7:0] opcode_i, operand_i, acc_i, index_i, stack_hi_i, stack_lo_i;
   logic [13:0] irq_vec_i, pc_o, table_addr_o;
   mcd_pkg::mcd_op_t op_o;
   mcd_pkg::mcd_mode_t mode_o;
   logic [3:0] cycles_o;
   logic illegal_o, busy_o, done_o, halted_o, push_o, restore_flags_o, carry_o, zero_o;
   logic [7:0] port_addr_o, push_hi_o, push_lo_o;
   logic [31:0] seed = 32'd80611;
   int fails = 0;
   int checks = 0;
   mcd_decoder dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .opcode_valid_i(opcode_valid_i),
      .opcode_i(opcode_i), .operand_i(operand_i), .acc_i(acc_i), .index_i(index_i),
      .carry_i(carry_i), .zero_i(zero_i), .irq_ack_i(irq_ack_i), .irq_vec_i(irq_vec_i),
      .stack_hi_i(stack_hi_i), .stack_lo_i(stack_lo_i), .op_o(op_o), .mode_o(mode_o),
      .cycles_o(cycles_o), .illegal_o(illegal_o), .busy_o(busy_o), .done_o(done_o),
      .halted_o(halted_o), .pc_o(pc_o), .port_addr_o(port_addr_o), .table_addr_o(table_addr_o),
      .push_o(push_o), .push_hi_o(push_hi_o), .push_lo_o(push_lo_o),
      .restore_flags_o(restore_flags_o), .carry_o(carry_o), .zero_o(zero_o));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic mcd_pkg::mcd_op_t exp_op(input logic [7:0] o);
      case (o) inside
         8'h00: return mcd_pkg::op_halt;
         [8'h01:8'h03]: return mcd_pkg::op_add;
         [8'h04:8'h06]: return mcd_pkg::op_add_carry;
         [8'h07:8'h09]: return mcd_pkg::op_sub;
         [8'h0A:8'h0C]: return mcd_pkg::op_subtract_with_borrow;
         [8'h0D:8'h0F]: return mcd_pkg::op_or;
         [8'h10:8'h12]: return mcd_pkg::op_and;
         [8'h13:8'h15]: return mcd_pkg::op_xor;
         [8'h16:8'h18]: return mcd_pkg::op_cmp;
         [8'h19:8'h1B]: return mcd_pkg::op_load_acc;
         8'h1C, 8'h1D: return mcd_pkg::op_load_idx;
         8'h1F: return mcd_pkg::op_page_advance;
         8'h20: return mcd_pkg::op_nop;
         8'h21: return mcd_pkg::op_inc_acc;
         8'h22: return mcd_pkg::op_inc_idx;
         8'h23, 8'h24: return mcd_pkg::op_inc_mem;
         8'h25: return mcd_pkg::op_dec_acc;
         8'h26: return mcd_pkg::op_dec_idx;
         8'h27, 8'h28: return mcd_pkg::op_dec_mem;
         8'h29: return mcd_pkg::op_port_read;
         8'h2A: return mcd_pkg::op_port_write;
         8'h39: return mcd_pkg::op_indexed_port_write;
         8'h2B: return mcd_pkg::op_pop_acc;
         8'h2C: return mcd_pkg::op_pop_idx;
         8'h2D: return mcd_pkg::op_push_acc;
         8'h2E: return mcd_pkg::op_push_idx;
         8'h2F: return mcd_pkg::op_swap_idx;
         8'h30: return mcd_pkg::op_swap_dsp;
         8'h31, 8'h32: return mcd_pkg::op_store_acc;
         8'h33, 8'h34: return mcd_pkg::op_or_mem;
         8'h35, 8'h36: return mcd_pkg::op_and_mem;
         8'h37, 8'h38: return mcd_pkg::op_xor_mem;
         8'h3A: return mcd_pkg::op_complement_acc;
         8'h3B: return mcd_pkg::op_shift_left_arith;
         8'h3C: return mcd_pkg::op_shift_right_arith;
         8'h3D: return mcd_pkg::op_rotate_left_carry;
         8'h3E: return mcd_pkg::op_rotate_right_carry;
         8'h3F: return mcd_pkg::op_ret;
         8'h70: return mcd_pkg::op_irq_mask_all;
         8'h72: return mcd_pkg::op_irq_unmask_all;
         8'h73: return mcd_pkg::op_return_from_interrupt;
         8'h40: return mcd_pkg::op_idx_to_acc;
         8'h41: return mcd_pkg::op_acc_to_idx;
         8'h60: return mcd_pkg::op_acc_to_psp;
         [8'h50:8'h5F], [8'h90:8'h9F]: return mcd_pkg::op_call;
         [8'h80:8'h8F]: return mcd_pkg::op_jump;
         [8'hA0:8'hAF]: return mcd_pkg::op_branch_if_zero;
         [8'hB0:8'hBF]: return mcd_pkg::op_branch_if_nonzero;
         [8'hC0:8'hCF]: return mcd_pkg::op_branch_if_carry;
         [8'hD0:8'hDF]: return mcd_pkg::op_branch_if_no_carry;
         [8'hE0:8'hEF]: return mcd_pkg::op_jump_accumulator_relative;
         [8'hF0:8'hFF]: return mcd_pkg::op_table_read;
         default: return mcd_pkg::op_illegal;
      endcase
   endfunction
   function automatic logic [3:0] exp_cyc(input logic [7:0] o);
      logic [3:0] m3;
      m3 = 4'((o - 8'h01) % 3);
      case (o) inside
         [8'h01:8'h15]: return 4'h4 + m3 + (m3 != 4'h0);
         [8'h16:8'h18]: return 4'h5 + m3 + (m3 != 4'h0);
         [8'h19:8'h1D]: return 4'h4 + m3;
         8'h29, 8'h2A, [8'h2D:8'h31], [8'h80:8'h8F], [8'hA0:8'hDF]: return 4'h5;
         8'h32, 8'h39: return 4'h6;
         8'h00, 8'h23, 8'h27, 8'h33, 8'h35, 8'h37, [8'hE0:8'hEF]: return 4'h7;
         8'h24, 8'h28, 8'h34, 8'h36, 8'h38, 8'h3F, 8'h73: return 4'h8;
         [8'h50:8'h5F], [8'h90:8'h9F]: return 4'hA;
         [8'hF0:8'hFF]: return 4'hE;
         default: return 4'h4;
      endcase
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic run(input logic [7:0] o, input logic [7:0] d, input logic irq);
      logic [13:0] p0;
      logic [13:0] ret;
      int n;
      p0 = pc_o;
      ret = {p0[13:8], p0[7:0] + 8'h02};
      @(posedge core_clk_i);
      opcode_i <= o; operand_i <= d; opcode_valid_i <= !irq; irq_ack_i <= irq;
      {acc_i, index_i, stack_hi_i, stack_lo_i} <= rnd();
      {carry_i, zero_i, irq_vec_i} <= 16'(rnd());
      @(posedge core_clk_i);
      opcode_valid_i <= 1'b0;
      irq_ack_i <= 1'b0;
      #1;
      if (irq) chk({push_o, push_hi_o, push_lo_o}, {1'b1, carry_i, zero_i, p0});
      else begin
         chk(op_o, exp_op(o));
         chk(illegal_o, exp_op(o) == mcd_pkg::op_illegal);
         chk(cycles_o, exp_cyc(o));
         if (o >= 8'h01 && o <= 8'h1D) chk(mode_o, 32'((o - 8'h01) % 3 + 1));
         if (o == 8'h39) chk(port_addr_o, 8'(d + index_i));
         if (o >= 8'hF0) chk(table_addr_o, {2'b00, {o[3:0], d} + {4'h0, acc_i}});
         if (o == 8'h73) chk({restore_flags_o, carry_o, zero_o}, {1'b1, stack_hi_i[7:6]});
         if (exp_op(o) == mcd_pkg::op_call)
            chk({push_o, push_hi_o, push_lo_o}, {1'b1, carry_i, zero_i, ret});
      end
      n = 0;
      while (busy_o === 1'b1 && n < 20) begin
         n++;
         @(posedge core_clk_i);
         #1;
      end
      chk(n, irq ? 4'hA : exp_cyc(o));
      chk(done_o, 1'b1);
      if (irq) chk(pc_o, irq_vec_i);
      else if (exp_op(o) == mcd_pkg::op_call) chk(pc_o, {p0[13], o[7], o[3:0], d});
      else if (exp_op(o) == mcd_pkg::op_jump) chk(pc_o, {p0[13:12], o[3:0], d});
      else if (o == 8'h1F) chk(pc_o[13:8], 6'(p0[13:8] + 6'h01));
      else if (o >= 8'h01 && o <= 8'h1D) chk(pc_o, ret);
      else if (o == 8'h20 || o == 8'h21) chk(pc_o, {p0[13:8], p0[7:0] + 8'h01});
   endtask
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = !core_clk_i;
   end
   initial begin
      repeat (60000) @(posedge core_clk_i);
      fails++;
      tally_and_finish();
   end
   initial begin
      rst_n_i = 1'b0; opcode_valid_i = 1'b0; irq_ack_i = 1'b0; carry_i = 1'b0; zero_i = 1'b0;
      opcode_i = 8'h00; operand_i = 8'h00; acc_i = 8'h00; index_i = 8'h00;
      stack_hi_i = 8'h00; stack_lo_i = 8'h00; irq_vec_i = 14'h0000;
      repeat (5) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      #1 chk(pc_o, 14'h0000);
      // Page wrap, reserved code, zero port field, interrupt entry
      run(8'h80, 8'hFF, 1'b0);
      run(8'h01, 8'h55, 1'b0);
      run(8'h1E, 8'h00, 1'b0);
      run(8'h39, 8'h00, 1'b0);
      run(8'h00, 8'h00, 1'b1);
      for (int i = 1; i < 256; i++) run(8'(i), 8'(rnd()), 1'b0);
      repeat (300) run(8'(rnd() | 32'h0000_0001), 8'(rnd()), 1'b0);
      run(8'h00, 8'h00, 1'b0);
      chk(halted_o, 1'b1);
      @(posedge core_clk_i) opcode_valid_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      #1 chk(busy_o, 1'b0);
      tally_and_finish();
   end
endmodule // tb_mcu_opcode_decoder
